// ### inc/dcsp_pkg.sv
// constants, field layout and state codes of the conversion and read-out block
// assumes one 50 MHz system clock; all pins arrive synchronous to it
package dcsp_pkg;
	// data layout of one result word: converter a above converter b
	localparam int RES_W = 12;
	localparam int WORD_W = 2 * RES_W;
	localparam int WORD_A_MSB = WORD_W - 1;
	localparam int WORD_B_MSB = RES_W - 1;
	localparam int FIFO_DEPTH = 8;

	// configuration word shifted in during a read frame
	localparam int CFG_W = 16;
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

	// conversion length in external clock periods, from the fastest clock
	localparam int CONV_TIME_PS = 406250;
	localparam int EXT_PERIOD_MIN_PS = 31250;
	localparam int CONV_EXT_CYCLES = (CONV_TIME_PS + EXT_PERIOD_MIN_PS - 1) / EXT_PERIOD_MIN_PS;

	// strobe setup before an external rise, as system clock cycles
	localparam int SYS_PERIOD_NS = 20;
	localparam int STROBE_SETUP_NS = 10;
	localparam int STROBE_HOLD_NS = 5;
	localparam int STROBE_SETUP_RAW = (STROBE_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int STROBE_SETUP_CYC = (STROBE_SETUP_RAW < 1) ? 1 : STROBE_SETUP_RAW;

	// counter widths and sized limits
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_EXT_CYCLES - 1);
	localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(STROBE_SETUP_CYC - 1); // detection edge counts as one
	localparam logic [CNT_W-1:0] BITS_DUAL = CNT_W'(RES_W);
	localparam logic [CNT_W-1:0] BITS_SINGLE = CNT_W'(WORD_W);
	localparam logic [CNT_W-1:0] CFG_LAST = CNT_W'(CFG_W - 1);

	typedef enum logic [3:0] {
		CV_IDLE = 4'b0001,
		CV_HOLD = 4'b0010,
		CV_CONV = 4'b0100,
		CV_PUSH = 4'b1000
	} dcsp_conv_state_t;
endpackage : dcsp_pkg

// ### inc/dcsp_stream_if.sv
// valid/ready word stream between the block's own modules
// assumes both ends share clk_sys
interface dcsp_stream_if #(parameter int W = 24);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : dcsp_stream_if

// ### design/dcsp_fifo.sv
// result buffer: flip-flop storage with honest full and empty
// assumes one clock; push and pop may happen in the same cycle
module dcsp_fifo #(
	parameter int W = 24,
	parameter int D = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	dcsp_stream_if.snk wr,
	dcsp_stream_if.src rd
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
	localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

	logic [W-1:0] mem_ff [D];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] cnt_ff;
	wire push = wr.valid & wr.ready;
	wire pop = rd.valid & rd.ready;
	wire [AW-1:0] nxt_wr_ptr = (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
	wire [AW-1:0] nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;

	// full refuses the writer, which stalls the converter
	assign wr.ready = (cnt_ff != FULL_CNT);
	assign rd.valid = (cnt_ff != '0);
	assign rd.data = mem_ff[rd_ptr_ff];

	// storage needs no reset, the count guards it
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= wr.data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) wr_ptr_ff <= nxt_wr_ptr;
			if (pop) rd_ptr_ff <= nxt_rd_ptr;
			if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule : dcsp_fifo

// ### design/dcsp_shifter.sv
// serial read-out: one word per frame, one or two lanes
// assumes edge pulses of the external clock arrive as one-cycle enables
module dcsp_shifter
	import dcsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ext_rise,
	input wire logic cs_n,
	input wire logic frame_start,
	input wire logic lane_dual,
	dcsp_stream_if.snk src,
	output logic sdo_a_ff,
	output logic sdo_b_ff,
	output logic frame_live_ff
);
	logic [WORD_W-1:0] shreg_ff;
	logic [CNT_W-1:0] bits_left_ff;
	logic active_ff;
	logic shown_ff;
	logic dual_ff;

	// an empty buffer still gives a frame, of zeros
	wire take = frame_start & ~active_ff;
	wire [WORD_W-1:0] load_word = src.valid ? src.data : '0;
	assign src.ready = take;

	// dual lanes shift each half on its own
	wire [RES_W-1:0] half_a = shreg_ff[WORD_A_MSB -: RES_W];
	wire [RES_W-1:0] half_b = shreg_ff[WORD_B_MSB -: RES_W];
	wire [WORD_W-1:0] shift_dual = {half_a[RES_W-2:0], 1'b0, half_b[RES_W-2:0], 1'b0};
	wire [WORD_W-1:0] shift_single = {shreg_ff[WORD_W-2:0], 1'b0};
	wire [WORD_W-1:0] nxt_shreg = dual_ff ? shift_dual : shift_single;
	wire last_bit = (bits_left_ff == 5'h01);
	wire step = active_ff & ext_rise;

	// bits change on a rise so they are settled at the fall
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shreg_ff <= '0;
			bits_left_ff <= '0;
			active_ff <= 1'b0;
			shown_ff <= 1'b0;
			dual_ff <= 1'b0;
			sdo_a_ff <= 1'b0;
			sdo_b_ff <= 1'b0;
			frame_live_ff <= 1'b0;
		end else if (take) begin
			shreg_ff <= load_word;
			dual_ff <= lane_dual;
			bits_left_ff <= lane_dual ? BITS_DUAL : BITS_SINGLE;
			active_ff <= 1'b1;
			shown_ff <= 1'b0;
		end else if (active_ff && cs_n) begin
			// deselect abandons the frame
			active_ff <= 1'b0;
			frame_live_ff <= 1'b0;
			sdo_a_ff <= 1'b0;
			sdo_b_ff <= 1'b0;
		end else if (step && !shown_ff) begin
			shown_ff <= 1'b1;
			frame_live_ff <= 1'b1;
			sdo_a_ff <= shreg_ff[WORD_A_MSB];
			sdo_b_ff <= dual_ff & shreg_ff[WORD_B_MSB];
		end else if (step && last_bit) begin
			active_ff <= 1'b0;
			frame_live_ff <= 1'b0;
			sdo_a_ff <= 1'b0;
			sdo_b_ff <= 1'b0;
		end else if (step) begin
			shreg_ff <= nxt_shreg;
			bits_left_ff <= bits_left_ff - 1'b1;
			sdo_a_ff <= nxt_shreg[WORD_A_MSB];
			sdo_b_ff <= dual_ff & nxt_shreg[WORD_B_MSB];
		end
	end
endmodule : dcsp_shifter

// ### design/dcsp_top.sv
// conversion control and serial port of a dual sampling converter
// assumes every pin, the external clock among them, is sampled by clk_sys
// and that the external clock is well below half the system rate
module dcsp_top
	import dcsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ext_clk,
	input wire logic convert_start_strobe,
	input wire logic cs_n,
	input wire logic read_sync,
	input wire logic config_serial_in,
	input wire logic input_channel_select,
	input wire logic output_lane_select,
	input wire logic [RES_W-1:0] conv_a_result,
	input wire logic [RES_W-1:0] conv_b_result,
	output logic sample_hold,
	output logic busy,
	output logic channel_pair,
	output logic serial_out_conv_a,
	output logic serial_out_conv_b,
	output logic serial_out_oe_n,
	output logic [CFG_W-1:0] config_word
);
	// pin samples and previous values for edge finding
	logic ext_ff;
	logic ext_prev_ff;
	logic strobe_ff;
	logic strobe_prev_ff;
	logic cs_n_ff;
	logic rd_ff;
	logic cfg_in_ff;
	logic chan_ff;
	logic lane_ff;

	// conversion sequencer
	dcsp_conv_state_t state_ff;
	dcsp_conv_state_t nxt_state;
	logic [CNT_W-1:0] since_ff;
	logic [CNT_W-1:0] conv_cnt_ff;
	logic hold_ff;
	logic busy_ff;
	logic channel_ff;

	// configuration capture
	logic [CFG_W-1:0] cfg_shreg_ff;
	logic [CNT_W-1:0] cfg_cnt_ff;
	logic [CFG_W-1:0] config_ff;
	logic oe_n_ff;

	// read-out wiring
	logic frame_live;
	logic sdo_a;
	logic sdo_b;

	dcsp_stream_if #(.W(WORD_W)) res_in ();
	dcsp_stream_if #(.W(WORD_W)) res_out ();

	// one register stage on every pin but the two result buses; inputs are already synchronous
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
			strobe_ff <= 1'b0;
			strobe_prev_ff <= 1'b0;
			cs_n_ff <= 1'b1;
			rd_ff <= 1'b0;
			cfg_in_ff <= 1'b0;
			chan_ff <= 1'b0;
			lane_ff <= 1'b0;
		end else begin
			ext_ff <= ext_clk;
			ext_prev_ff <= ext_ff;
			strobe_ff <= convert_start_strobe;
			strobe_prev_ff <= strobe_ff;
			cs_n_ff <= cs_n;
			rd_ff <= read_sync;
			cfg_in_ff <= config_serial_in;
			chan_ff <= input_channel_select;
			lane_ff <= output_lane_select;
		end
	end

	// edge enables of the external clock and the strobe
	wire ext_rise = ext_ff & ~ext_prev_ff;
	wire ext_fall = ~ext_ff & ext_prev_ff;
	wire strobe_rise = strobe_ff & ~strobe_prev_ff;

	// a read pulse counts only at a fall while selected
	wire frame_start = ext_fall & rd_ff & ~cs_n_ff;

	// sequencer decode
	wire st_idle = (state_ff == CV_IDLE);
	wire st_hold = (state_ff == CV_HOLD);
	wire st_conv = (state_ff == CV_CONV);
	wire st_push = (state_ff == CV_PUSH);
	// a strobe seen too close to a rise waits for the next one
	wire setup_met = (since_ff >= SETUP_CNT);
	wire conv_go = st_hold & ext_rise & setup_met;
	wire conv_end = st_conv & ext_rise & (conv_cnt_ff == CONV_LAST);
	wire want_push = conv_end | st_push;
	wire pushed = want_push & res_in.ready;

	// result word toward the buffer
	assign res_in.valid = want_push;
	assign res_in.data = {conv_a_result, conv_b_result};

	// next state; strobes during a conversion are ignored
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CV_IDLE: begin
				if (strobe_rise) nxt_state = CV_HOLD;
			end
			CV_HOLD: begin
				if (conv_go) nxt_state = CV_CONV;
			end
			CV_CONV: begin
				// a full buffer stalls completion, so busy stays up
				if (conv_end) nxt_state = pushed ? CV_IDLE : CV_PUSH;
			end
			CV_PUSH: begin
				if (pushed) nxt_state = CV_IDLE;
			end
			default: begin
				nxt_state = CV_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= CV_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// cycles since hold, saturating so a slow clock cannot wrap it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			since_ff <= '0;
		end else if (st_idle) begin
			since_ff <= '0;
		end else if (st_hold && since_ff != '1) begin
			since_ff <= since_ff + 1'b1;
		end
	end

	// conversion length in external clock rises
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt_ff <= '0;
		end else if (conv_go) begin
			conv_cnt_ff <= '0;
		end else if (st_conv && ext_rise && !conv_end) begin
			conv_cnt_ff <= conv_cnt_ff + 1'b1;
		end
	end

	// hold and busy rise with the strobe, fall once the word is stored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (st_idle && strobe_rise) begin
			hold_ff <= 1'b1;
			busy_ff <= 1'b1;
		end else if (pushed) begin
			hold_ff <= 1'b0;
			busy_ff <= 1'b0;
		end
	end

	// channel pair is frozen for the whole conversion
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			channel_ff <= 1'b0;
		end else if (st_idle && strobe_rise) begin
			channel_ff <= chan_ff;
		end
	end

	// config bits enter at the same falls the host reads on
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_shreg_ff <= '0;
			cfg_cnt_ff <= '0;
		end else if (frame_start) begin
			cfg_cnt_ff <= '0;
		end else if (ext_fall && frame_live && cfg_cnt_ff <= CFG_LAST) begin
			cfg_shreg_ff <= {cfg_shreg_ff[CFG_W-2:0], cfg_in_ff};
			cfg_cnt_ff <= cfg_cnt_ff + 1'b1;
		end
	end

	// only a complete word takes effect; otherwise the last complete word, or CFG_RESET after reset, stays
	wire cfg_done = ext_fall & frame_live & (cfg_cnt_ff == CFG_LAST);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			config_ff <= CFG_RESET;
		end else if (cfg_done) begin
			config_ff <= {cfg_shreg_ff[CFG_W-2:0], cfg_in_ff};
		end
	end

	// pin driver enable follows select, low while driving
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			oe_n_ff <= 1'b1;
		end else begin
			oe_n_ff <= cs_n_ff;
		end
	end

	// result buffer between converter and serial port
	dcsp_fifo #(
		.W(WORD_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr(res_in),
		.rd(res_out)
	);

	// serial shifter; lane layout is taken at each frame start
	dcsp_shifter u_shift (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ext_rise(ext_rise),
		.cs_n(cs_n_ff),
		.frame_start(frame_start),
		.lane_dual(lane_ff),
		.src(res_out),
		.sdo_a_ff(sdo_a),
		.sdo_b_ff(sdo_b),
		.frame_live_ff(frame_live)
	);

	// all outputs leave straight from flip-flops
	assign sample_hold = hold_ff;
	assign busy = busy_ff;
	assign channel_pair = channel_ff;
	assign serial_out_conv_a = sdo_a;
	assign serial_out_conv_b = sdo_b;
	assign serial_out_oe_n = oe_n_ff;
	assign config_word = config_ff;
endmodule : dcsp_top

// ### tb/dcsp_chk.sv
// port checker of the conversion and read-out block
// assumes it is bound to dcsp_top and sees only its ports
module dcsp_chk
	import dcsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ext_clk,
	input wire logic convert_start_strobe,
	input wire logic cs_n,
	input wire logic read_sync,
	input wire logic config_serial_in,
	input wire logic input_channel_select,
	input wire logic output_lane_select,
	input wire logic [RES_W-1:0] conv_a_result,
	input wire logic [RES_W-1:0] conv_b_result,
	input wire logic sample_hold,
	input wire logic busy,
	input wire logic channel_pair,
	input wire logic serial_out_conv_a,
	input wire logic serial_out_conv_b,
	input wire logic serial_out_oe_n,
	input wire logic [CFG_W-1:0] config_word
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic ext_ff;
	logic busy_ff;
	logic [7:0] rise_ff;
	logic [7:0] nxt_rise;
	// ext rises while busy; first busy cycle skipped, so a lower bound only
	assign nxt_rise = (busy && !busy_ff) ? 8'h00 : rise_ff + 8'(busy && ext_clk && !ext_ff);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_ff <= 1'b0;
			busy_ff <= 1'b0;
			rise_ff <= 8'h00;
		end else begin
			ext_ff <= ext_clk;
			busy_ff <= busy;
			rise_ff <= nxt_rise;
		end
	end
	sequence s_start;
		$rose(convert_start_strobe) && !busy;
	endsequence
	sequence s_held;
		##[1:4] (busy && sample_hold);
	endsequence
	AST_BUSY_RISE: assert property (s_start |-> s_held) else $error("no hold after strobe");
	AST_HOLD_BUSY: assert property (busy == sample_hold) else $error("hold and busy differ");
	AST_CONV_RISES: assert property ($fell(busy) |-> rise_ff >= 8'h0d) else $error("conversion short");
	AST_CH_STABLE: assert property (busy && $past(busy) |-> $stable(channel_pair)) else $error("pair moved");
	AST_OE: assert property (serial_out_oe_n == $past(cs_n, 2)) else $error("enable wrong");
	AST_DESEL: assert property (cs_n [*3] |-> !serial_out_conv_a && !serial_out_conv_b) else $error("lane busy");
	AST_LANE_B: assert property (!output_lane_select [*4] |-> !serial_out_conv_b) else $error("lane b on");
	AST_SDO_PHASE: assert property ($changed(serial_out_conv_a) && !cs_n && !$past(cs_n, 3)
		|-> $past(ext_clk, 2)) else $error("bit moved near fall");
	AST_CFG_SEL: assert property ($changed(config_word) |-> !$past(cs_n, 2)) else $error("cfg unselected");
endmodule : dcsp_chk

bind dcsp_top dcsp_chk chk (.*);

// ### tb/dcsp_host.sv
// host model: free external clock, strobe and read frames
// assumes clk_sys at 50 MHz; ext clock is 8 system cycles a period
module dcsp_host (
	input wire logic clk_sys,
	input wire logic rst_n,
	output logic ext_clk,
	output logic strobe,
	output logic cs_n,
	output logic read_sync,
	output logic cfg_in,
	output logic ch_sel,
	input wire logic sdo_a,
	input wire logic sdo_b
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] div_ff = 3'h0;
	initial begin
		ext_clk = 1'b0;
		strobe = 1'b0;
		cs_n = 1'b1;
		read_sync = 1'b0;
		cfg_in = 1'b0;
		ch_sel = 1'b0;
	end
	// clock runs free, low while in reset
	always @(posedge clk_sys) begin
		div_ff <= #2 rst_n ? div_ff + 3'h1 : 3'h0;
		ext_clk <= #2 rst_n & div_ff[2];
	end
	// returns at the edge just before the pin falls
	task fall();
		do @(posedge clk_sys); while (div_ff != 3'h0);
	endtask : fall
	task step();
		fall();
		@(posedge clk_sys);
		#2;
	endtask : step
	// off counts edges after a fall; 4 would land on the rise itself
	task conv(input logic c, input int off);
		fall();
		repeat (off) @(posedge clk_sys);
		#2 ch_sel = c;
		strobe = 1'b1;
		repeat (2) @(posedge clk_sys);
		#2 strobe = 1'b0;
	endtask : conv
	task ghost();
		step();
		read_sync = 1'b1;
		step();
		read_sync = 1'b0;
	endtask : ghost
	task rd(input int n, input logic [15:0] cfg, output logic [23:0] a, output logic [23:0] b);
		logic [15:0] c;
		c = cfg;
		a = 24'h0;
		b = 24'h0;
		step();
		cs_n = 1'b0;
		step();
		read_sync = 1'b1;
		step();
		read_sync = 1'b0;
		for (int i = 0; i < n; i++) begin
			cfg_in = c[15];
			c = c << 1;
			step();
			a = {a[22:0], sdo_a};
			b = {b[22:0], sdo_b};
		end
		step();
		cs_n = 1'b1;
	endtask : rd
endmodule : dcsp_host

// ### tb/tb.sv
// self-checking bench of dcsp_top with a host model
// assumes the design package is compiled first
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic lane = 1'b0;
	logic ext_clk, strobe, cs_n, rd_sync, cfg_in, ch;
	logic hold, busy, pair, sdo_a, sdo_b, oe_n;
	logic [11:0] res_a = 12'h0;
	logic [11:0] res_b = 12'h0;
	logic [15:0] cfg_word;
	logic [15:0] ecfg = 16'h0;
	logic [31:0] seed = 32'h8abf34bc;
	logic [23:0] q[$];
	logic [23:0] ga, gb, pend;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_rise = 0;
	int rise_mark = 0;
	always #10 clk_sys = ~clk_sys;
	// host clock rises seen since the accepted strobe
	always @(posedge ext_clk) n_rise++;
	always @(posedge strobe) begin
		if (!busy) rise_mark = n_rise;
	end
	dcsp_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .ext_clk(ext_clk), .convert_start_strobe(strobe),
		.cs_n(cs_n), .read_sync(rd_sync), .config_serial_in(cfg_in), .input_channel_select(ch),
		.output_lane_select(lane), .conv_a_result(res_a), .conv_b_result(res_b), .sample_hold(hold),
		.busy(busy), .channel_pair(pair), .serial_out_conv_a(sdo_a), .serial_out_conv_b(sdo_b),
		.serial_out_oe_n(oe_n), .config_word(cfg_word));
	dcsp_host host (.clk_sys(clk_sys), .rst_n(rst_n), .ext_clk(ext_clk), .strobe(strobe), .cs_n(cs_n),
		.read_sync(rd_sync), .cfg_in(cfg_in), .ch_sel(ch), .sdo_a(sdo_a), .sdo_b(sdo_b));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task chk(input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task wait_busy(input logic v, input int lim);
		for (int i = 0; i < lim && busy !== v; i++) @(posedge clk_sys);
		if (busy !== v) begin
			n_mismatch++;
			end_of_test();
		end
	endtask : wait_busy
	// model buffer holds eight words; a ninth waits in pend
	task convert(input logic c, input logic again, input int off);
		host.conv(c, off);
		seed = lfsr(seed);
		res_a = seed[11:0];
		res_b = seed[27:16];
		wait_busy(1'b1, 8);
		if (again) host.conv(~c, 0);
		if (q.size() < 8) begin
			q.push_back({res_a, res_b});
			wait_busy(1'b0, 200);
			chk(24'(dcsp_pkg::CONV_EXT_CYCLES + 1), 24'(n_rise - rise_mark));
			chk(24'(c), 24'(pair));
		end else begin
			pend = {res_a, res_b};
		end
	endtask : convert
	task read(input logic dual);
		logic [23:0] e;
		e = (q.size() > 0) ? q.pop_front() : 24'h0;
		seed = lfsr(seed);
		@(posedge clk_sys);
		#2 lane = dual;
		host.rd(dual ? 12 : 24, seed[15:0], ga, gb);
		if (!dual) ecfg = seed[15:0];
		chk(dual ? {12'h0, e[23:12]} : e, ga);
		chk(dual ? {12'h0, e[11:0]} : 24'h0, gb);
		chk(24'(ecfg), 24'(cfg_word));
		repeat (3) @(posedge clk_sys);
		#2;
		chk(24'h1, 24'(oe_n));
	endtask : read
	initial begin
		repeat (12) @(posedge clk_sys);
		#2 rst_n = 1'b1;
		chk(24'h1, 24'({hold, busy, pair, sdo_a, sdo_b, oe_n}));
		chk(24'h0, 24'(cfg_word));
		// every channel and lane setting
		for (int k = 0; k < 4; k++) begin
			convert(k[0], 1'b0, k[1] ? 5 : 3);
			read(k[1]);
			$display("combo %0d done", k);
		end
		// empty buffer, then a pulse while deselected
		read(1'b0);
		convert(1'b1, 1'b1, 0);
		host.ghost();
		read(1'b0);
		$display("refusals done");
		// fill until the buffer stalls busy, then drain
		for (int k = 0; k < 9; k++) convert(k[1], 1'b0, 0);
		repeat (200) @(posedge clk_sys);
		chk(24'h1, 24'(busy));
		read(1'b0);
		wait_busy(1'b0, 50);
		q.push_back(pend);
		for (int k = 0; k < 9; k++) read(k[0]);
		$display("buffer done");
		end_of_test();
	end
endmodule : tb
